/* bsbu_pkg.sv */
// Shared constants and types for the byte shift and bit operation unit
package bsbu_pkg;

  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned BITN_W   = 3;
  localparam int unsigned OP_W     = 5;
  localparam int unsigned ADDR_W   = 16;
  // Value seen when the read phase touches a write-only location
  localparam logic [7:0]  WO_READ_VALUE = 8'hFF;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [2:0]  BITN_RESET    = 3'h0;

  // Operation codes presented by the instruction decoder
  typedef enum logic [4:0] {
    OP_ARITH_SHIFT_LEFT       = 5'h00,
    OP_ARITH_SHIFT_RIGHT      = 5'h01,
    OP_LOGIC_SHIFT_LEFT       = 5'h02,
    OP_LOGIC_SHIFT_RIGHT      = 5'h03,
    OP_ROTATE_LEFT            = 5'h04,
    OP_ROTATE_RIGHT           = 5'h05,
    OP_ROTATE_LEFT_VIA_CARRY  = 5'h06,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'h07,
    OP_BIT_SET                = 5'h08,
    OP_BIT_CLEAR              = 5'h09,
    OP_BIT_INVERT             = 5'h0A,
    OP_BIT_TEST               = 5'h0B,
    OP_CARRY_AND_BIT          = 5'h0C,
    OP_CARRY_AND_INV_BIT      = 5'h0D,
    OP_CARRY_OR_BIT           = 5'h0E,
    OP_CARRY_OR_INV_BIT       = 5'h0F,
    OP_CARRY_XOR_BIT          = 5'h10,
    OP_CARRY_XOR_INV_BIT      = 5'h11,
    OP_BIT_TO_CARRY           = 5'h12,
    OP_INV_BIT_TO_CARRY       = 5'h13,
    OP_CARRY_TO_BIT           = 5'h14,
    OP_INV_CARRY_TO_BIT       = 5'h15
  } bsbu_op_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_READ   = 4'h2,
    ST_MODIFY = 4'h4,
    ST_WRITE  = 4'h8
  } bsbu_state_t;

  // Operations whose bit number may only come from the immediate field
  function automatic logic bsbu_is_inverted(input bsbu_op_t op);
    return (op == OP_CARRY_AND_INV_BIT) || (op == OP_CARRY_OR_INV_BIT) ||
           (op == OP_CARRY_XOR_INV_BIT) || (op == OP_INV_BIT_TO_CARRY) ||
           (op == OP_INV_CARRY_TO_BIT);
  endfunction

  // Shift and rotate group works on general registers only
  function automatic logic bsbu_is_shift(input bsbu_op_t op);
    return (op <= OP_ROTATE_RIGHT_VIA_CARRY);
  endfunction

  // One-hot mask for a bit number
  function automatic logic [7:0] bsbu_bit_mask(input logic [2:0] bitn);
    return 8'h01 << bitn;
  endfunction

endpackage

/* bsbu_alu_if.sv */
// Carrier between the sequencer and the combinational operation core
`timescale 1ns/1ps
interface bsbu_alu_if;
  logic                 [4:0] op;
  logic                 [7:0] operand;
  logic                 [2:0] bitn;
  logic                       carry_in;
  logic                 [7:0] result;
  logic                       carry_out;
  logic                       carry_we;
  logic                       zero_out;
  logic                       zero_we;
  logic                       writes;

  modport seq (output op, operand, bitn, carry_in,
               input  result, carry_out, carry_we, zero_out, zero_we,
                      writes);
  modport core (input  op, operand, bitn, carry_in,
                output result, carry_out, carry_we, zero_out, zero_we,
                       writes);
endinterface

/* bsbu_alu.sv */
// Combinational core computing shift, rotate and single-bit results
`timescale 1ns/1ps
module bsbu_alu (
  bsbu_alu_if.core u_if
);

  bsbu_pkg::bsbu_op_t op;
  logic [7:0]         d;
  logic [7:0]         mask;
  logic               sel;
  logic               c;

  assign op   = bsbu_pkg::bsbu_op_t'(u_if.op);
  assign d    = u_if.operand;
  assign c    = u_if.carry_in;
  assign mask = bsbu_pkg::bsbu_bit_mask(u_if.bitn);
  assign sel  = d[u_if.bitn];

  // Result, flag and write-back decision per operation
  always_comb begin
    u_if.result    = d;
    u_if.carry_out = c;
    u_if.carry_we  = 1'b0;
    u_if.zero_out  = 1'b0;
    u_if.zero_we   = 1'b0;
    u_if.writes    = 1'b0;
    case (op)
      bsbu_pkg::OP_ARITH_SHIFT_LEFT: begin
        u_if.result    = {d[6:0], 1'b0};
        u_if.carry_out = d[7];
      end
      bsbu_pkg::OP_ARITH_SHIFT_RIGHT: begin
        u_if.result    = {d[7], d[7:1]};
        u_if.carry_out = d[0];
      end
      bsbu_pkg::OP_LOGIC_SHIFT_LEFT: begin
        u_if.result    = {d[6:0], 1'b0};
        u_if.carry_out = d[7];
      end
      bsbu_pkg::OP_LOGIC_SHIFT_RIGHT: begin
        u_if.result    = {1'b0, d[7:1]};
        u_if.carry_out = d[0];
      end
      bsbu_pkg::OP_ROTATE_LEFT: begin
        u_if.result    = {d[6:0], d[7]};
        u_if.carry_out = d[7];
      end
      bsbu_pkg::OP_ROTATE_RIGHT: begin
        u_if.result    = {d[0], d[7:1]};
        u_if.carry_out = d[0];
      end
      bsbu_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
        u_if.result    = {d[6:0], c};
        u_if.carry_out = d[7];
      end
      bsbu_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
        u_if.result    = {c, d[7:1]};
        u_if.carry_out = d[0];
      end
      bsbu_pkg::OP_BIT_SET: u_if.result = d | mask;
      bsbu_pkg::OP_BIT_CLEAR: u_if.result = d & ~mask;
      bsbu_pkg::OP_BIT_INVERT: u_if.result = d ^ mask;
      bsbu_pkg::OP_BIT_TEST: u_if.zero_out = ~sel;
      bsbu_pkg::OP_CARRY_AND_BIT: u_if.carry_out = c & sel;
      bsbu_pkg::OP_CARRY_AND_INV_BIT: u_if.carry_out = c & ~sel;
      // carry or bit, plain and inverse
      bsbu_pkg::OP_CARRY_OR_BIT: u_if.carry_out = c | sel;
      bsbu_pkg::OP_CARRY_OR_INV_BIT: u_if.carry_out = c | ~sel;
      // carry xor bit, plain and inverse
      bsbu_pkg::OP_CARRY_XOR_BIT: u_if.carry_out = c ^ sel;
      bsbu_pkg::OP_CARRY_XOR_INV_BIT: u_if.carry_out = c ^ ~sel;
      bsbu_pkg::OP_BIT_TO_CARRY: u_if.carry_out = sel;
      bsbu_pkg::OP_INV_BIT_TO_CARRY: u_if.carry_out = ~sel;
      bsbu_pkg::OP_CARRY_TO_BIT:
        u_if.result = c ? (d | mask) : (d & ~mask);
      bsbu_pkg::OP_INV_CARRY_TO_BIT:
        u_if.result = c ? (d & ~mask) : (d | mask);
      default: u_if.result = d;
    endcase
    // Shifts touch carry and zero; carry logic touches carry only
    if (bsbu_pkg::bsbu_is_shift(op)) begin
      u_if.carry_we = 1'b1;
      u_if.zero_we  = 1'b1;
      u_if.zero_out = (u_if.result == bsbu_pkg::DATA_RESET);
      u_if.writes   = 1'b1;
    end
    if (op >= bsbu_pkg::OP_CARRY_AND_BIT &&
        op <= bsbu_pkg::OP_INV_BIT_TO_CARRY) begin
      u_if.carry_we = 1'b1;
    end
    if (op == bsbu_pkg::OP_BIT_TEST) begin
      u_if.zero_we = 1'b1;
    end
    // test and carry ops never write
    if (op == bsbu_pkg::OP_BIT_SET || op == bsbu_pkg::OP_BIT_CLEAR ||
        op == bsbu_pkg::OP_BIT_INVERT || op == bsbu_pkg::OP_CARRY_TO_BIT ||
        op == bsbu_pkg::OP_INV_CARRY_TO_BIT) begin
      u_if.writes = 1'b1;
    end
  end

endmodule

/* bsbu_top.sv */
// Sequencer for byte shift and single-bit operations with memory RMW
`timescale 1ns/1ps

// Notes on behaviour
// - arithmetic shifts rewrite the same register
// - logical shifts rewrite the same register
// - plain rotates, no carry in loop
// - rotate through carry over nine positions
// - set forces selected bit to one
// - clear forces selected bit to zero
// - invert complements selected bit only
// - test loads zero with inverse bit
// - bit number from immediate or register
// - carry becomes carry AND bit
// - carry becomes carry AND inverse bit
// - carry ORs bit or its inverse
// - carry XORs bit or its inverse
// - load bit or inverse into carry
// - store carry or inverse into bit
// - inverted forms take immediate bit number only
// - writing ops read, modify, write same byte
// - write-only location reads back as all ones
module bsbu_top #(
  parameter int unsigned ADDR_W = bsbu_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  // Command from the instruction decoder
  input  wire logic              i_cmd_valid,
  input  wire logic [4:0]        i_cmd_op,
  input  wire logic              i_cmd_use_mem,
  input  wire logic              i_cmd_bit_from_reg,
  input  wire logic [2:0]        i_cmd_bit_imm,
  input  wire logic [7:0]        i_cmd_bit_reg,
  input  wire logic [7:0]        i_cmd_reg_data,
  input  wire logic [ADDR_W-1:0] i_cmd_addr,
  input  wire logic              i_carry,
  // Status to the decoder
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_error,
  // Register file write-back
  output logic                   o_reg_wr_en,
  output logic [7:0]             o_reg_wr_data,
  // Condition code updates
  output logic                   o_carry_wr_en,
  output logic                   o_carry,
  output logic                   o_zero_wr_en,
  output logic                   o_zero,
  // Memory and I/O bus
  output logic                   o_mem_rd,
  output logic                   o_mem_wr,
  output logic [ADDR_W-1:0]      o_mem_addr,
  output logic [7:0]             o_mem_wdata,
  input  wire logic [7:0]        i_mem_rdata,
  input  wire logic              i_mem_wo,
  input  wire logic              i_mem_ack
);

  // Refuse address widths the bus registers cannot hold
  if (ADDR_W < 1 || ADDR_W > 32) begin : g_addr_w_check
    $error("bsbu_top: ADDR_W must lie in 1..32");
  end

  bsbu_alu_if u_alu_if ();

  bsbu_alu u_alu (
    .u_if (u_alu_if.core)
  );

  // Sequencer state and latched operands
  bsbu_pkg::bsbu_state_t state_r;
  bsbu_pkg::bsbu_state_t state_nxt;
  logic [4:0]            op_r;
  logic [4:0]            op_nxt;
  logic [2:0]            bitn_r;
  logic [2:0]            bitn_nxt;
  logic                  use_mem_r;
  logic                  use_mem_nxt;
  logic [7:0]            data_r;
  logic [7:0]            data_nxt;
  logic                  carry_in_r;
  logic                  carry_in_nxt;
  // Output registers
  logic                  busy_r;
  logic                  busy_nxt;
  logic                  done_r;
  logic                  done_nxt;
  logic                  error_r;
  logic                  error_nxt;
  logic                  reg_wr_en_r;
  logic                  reg_wr_en_nxt;
  logic [7:0]            reg_wr_data_r;
  logic [7:0]            reg_wr_data_nxt;
  logic                  carry_wr_en_r;
  logic                  carry_wr_en_nxt;
  logic                  carry_r;
  logic                  carry_nxt;
  logic                  zero_wr_en_r;
  logic                  zero_wr_en_nxt;
  logic                  zero_r;
  logic                  zero_nxt;
  logic                  mem_rd_r;
  logic                  mem_rd_nxt;
  logic                  mem_wr_r;
  logic                  mem_wr_nxt;
  logic [ADDR_W-1:0]     mem_addr_r;
  logic [ADDR_W-1:0]     mem_addr_nxt;
  logic [7:0]            mem_wdata_r;
  logic [7:0]            mem_wdata_nxt;

  logic [2:0]            cmd_bitn;
  logic                  cmd_bad;

  // Decoder code seen as an operation, for the package helpers
  function automatic bsbu_pkg::bsbu_op_t as_op(input logic [4:0] code);
    return bsbu_pkg::bsbu_op_t'(code);
  endfunction

  // bit number from immediate or register low bits
  assign cmd_bitn = i_cmd_bit_from_reg ? i_cmd_bit_reg[2:0] : i_cmd_bit_imm;

  // refuse register-sourced bit number on inverted forms
  // Shifts on memory are refused as well; they exist for registers only
  assign cmd_bad =
    (bsbu_pkg::bsbu_is_inverted(as_op(i_cmd_op)) &&
     i_cmd_bit_from_reg) ||
    (bsbu_pkg::bsbu_is_shift(as_op(i_cmd_op)) &&
     i_cmd_use_mem) ||
    (i_cmd_op > bsbu_pkg::OP_INV_CARRY_TO_BIT);

  // Core sees only latched operands, so its result is stable in MODIFY
  assign u_alu_if.op       = op_r;
  assign u_alu_if.operand  = data_r;
  assign u_alu_if.bitn     = bitn_r;
  assign u_alu_if.carry_in = carry_in_r;

  // Next-state and output computation
  always_comb begin
    state_nxt       = state_r;
    op_nxt          = op_r;
    bitn_nxt        = bitn_r;
    use_mem_nxt     = use_mem_r;
    data_nxt        = data_r;
    carry_in_nxt    = carry_in_r;
    busy_nxt        = busy_r;
    done_nxt        = 1'b0;
    error_nxt       = 1'b0;
    reg_wr_en_nxt   = 1'b0;
    reg_wr_data_nxt = reg_wr_data_r;
    carry_wr_en_nxt = 1'b0;
    carry_nxt       = carry_r;
    zero_wr_en_nxt  = 1'b0;
    zero_nxt        = zero_r;
    mem_rd_nxt      = mem_rd_r;
    mem_wr_nxt      = mem_wr_r;
    mem_addr_nxt    = mem_addr_r;
    mem_wdata_nxt   = mem_wdata_r;

    // A command sent while busy is dropped without any sign
    case (state_r)
      bsbu_pkg::ST_IDLE: begin
        if (i_cmd_valid) begin
          if (cmd_bad) begin
            done_nxt  = 1'b1;
            error_nxt = 1'b1;
          end else begin
            op_nxt       = i_cmd_op;
            bitn_nxt     = cmd_bitn;
            use_mem_nxt  = i_cmd_use_mem;
            data_nxt     = i_cmd_reg_data;
            carry_in_nxt = i_carry;
            busy_nxt     = 1'b1;
            if (i_cmd_use_mem) begin
              // step one, read the whole byte
              mem_rd_nxt   = 1'b1;
              mem_addr_nxt = i_cmd_addr;
              state_nxt    = bsbu_pkg::ST_READ;
            end else begin
              state_nxt = bsbu_pkg::ST_MODIFY;
            end
          end
        end
      end

      bsbu_pkg::ST_READ: begin
        if (i_mem_ack) begin
          mem_rd_nxt = 1'b0;
          // Untouched bits go back as read, so a write-only place gets
          // ones there too; software keeps a shadow copy where it matters
          // write-only location returns all ones
          data_nxt   = i_mem_wo ? bsbu_pkg::WO_READ_VALUE : i_mem_rdata;
          state_nxt  = bsbu_pkg::ST_MODIFY;
        end
      end

      bsbu_pkg::ST_MODIFY: begin
        // Flags go out now, ahead of any memory write back
        carry_wr_en_nxt = u_alu_if.carry_we;
        carry_nxt       = u_alu_if.carry_out;
        zero_wr_en_nxt  = u_alu_if.zero_we;
        zero_nxt        = u_alu_if.zero_out;
        if (u_alu_if.writes && use_mem_r) begin
          // step three, write back to same address
          mem_wr_nxt    = 1'b1;
          mem_wdata_nxt = u_alu_if.result;
          state_nxt     = bsbu_pkg::ST_WRITE;
        end else begin
          // result returns to the source register
          reg_wr_en_nxt   = u_alu_if.writes;
          reg_wr_data_nxt = u_alu_if.result;
          done_nxt        = 1'b1;
          busy_nxt        = 1'b0;
          state_nxt       = bsbu_pkg::ST_IDLE;
        end
      end

      // Address and data hold until the bus answers; with no time-out, a
      // device that never answers leaves the unit busy
      bsbu_pkg::ST_WRITE: begin
        if (i_mem_ack) begin
          mem_wr_nxt = 1'b0;
          done_nxt   = 1'b1;
          busy_nxt   = 1'b0;
          state_nxt  = bsbu_pkg::ST_IDLE;
        end
      end

      // Stray state code: back to idle with the bus released
      default: begin
        state_nxt  = bsbu_pkg::ST_IDLE;
        busy_nxt   = 1'b0;
        mem_rd_nxt = 1'b0;
        mem_wr_nxt = 1'b0;
      end
    endcase
  end

  // State and output registers; reset loads constants only
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r       <= bsbu_pkg::ST_IDLE;
      op_r          <= 5'h00;
      bitn_r        <= bsbu_pkg::BITN_RESET;
      use_mem_r     <= 1'b0;
      data_r        <= bsbu_pkg::DATA_RESET;
      carry_in_r    <= 1'b0;
      busy_r        <= 1'b0;
      done_r        <= 1'b0;
      error_r       <= 1'b0;
      reg_wr_en_r   <= 1'b0;
      reg_wr_data_r <= bsbu_pkg::DATA_RESET;
      carry_wr_en_r <= 1'b0;
      carry_r       <= 1'b0;
      zero_wr_en_r  <= 1'b0;
      zero_r        <= 1'b0;
      mem_rd_r      <= 1'b0;
      mem_wr_r      <= 1'b0;
      mem_addr_r    <= '0;
      mem_wdata_r   <= bsbu_pkg::DATA_RESET;
    end else begin
      state_r       <= state_nxt;
      op_r          <= op_nxt;
      bitn_r        <= bitn_nxt;
      use_mem_r     <= use_mem_nxt;
      data_r        <= data_nxt;
      carry_in_r    <= carry_in_nxt;
      busy_r        <= busy_nxt;
      done_r        <= done_nxt;
      error_r       <= error_nxt;
      reg_wr_en_r   <= reg_wr_en_nxt;
      reg_wr_data_r <= reg_wr_data_nxt;
      carry_wr_en_r <= carry_wr_en_nxt;
      carry_r       <= carry_nxt;
      zero_wr_en_r  <= zero_wr_en_nxt;
      zero_r        <= zero_nxt;
      mem_rd_r      <= mem_rd_nxt;
      mem_wr_r      <= mem_wr_nxt;
      mem_addr_r    <= mem_addr_nxt;
      mem_wdata_r   <= mem_wdata_nxt;
    end
  end

  // Ports come straight from the registers
  assign o_busy        = busy_r;
  assign o_done        = done_r;
  assign o_error       = error_r;
  assign o_reg_wr_en   = reg_wr_en_r;
  assign o_reg_wr_data = reg_wr_data_r;
  assign o_carry_wr_en = carry_wr_en_r;
  assign o_carry       = carry_r;
  assign o_zero_wr_en  = zero_wr_en_r;
  assign o_zero        = zero_r;
  assign o_mem_rd      = mem_rd_r;
  assign o_mem_wr      = mem_wr_r;
  assign o_mem_addr    = mem_addr_r;
  assign o_mem_wdata   = mem_wdata_r;

endmodule

/* bsbu_mem_model.sv */
// Memory and I/O bus partner with adjustable acknowledge delay
`timescale 1ns/1ps
module bsbu_mem_model #(
  parameter logic [15:0] WO_ADDR = 16'h0005
) (
  // Clock and delay setting
  input  wire logic        i_clk_sys,
  input  wire logic [1:0]  i_lat,
  // Bus from the unit
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  // Answers and observation
  output logic      [7:0]  o_rdata,
  output logic             o_wo,
  output logic             o_ack,
  output logic      [7:0]  o_wr_cnt,
  output logic      [7:0]  o_last_wdata
);
  logic [7:0] mem [16];
  logic [1:0] cnt;

  // Every location starts at 3F so a write-only place differs from FF
  initial begin
    foreach (mem[i])
      mem[i] = 8'h3F;
    {o_rdata, o_wo, o_ack, cnt, o_wr_cnt, o_last_wdata} = '0;
  end

  // Answer just after the edge; released data toggles so no stale byte
  always @(posedge i_clk_sys) begin
    #1;
    if (o_ack) begin
      o_ack = 1'b0;
      o_wo = 1'b0;
      o_rdata = ~o_rdata;
    end else if ((i_rd || i_wr) && cnt < i_lat) begin
      cnt++;
      o_rdata = ~o_rdata;
    end else if (i_rd) begin
      cnt = 2'h0;
      o_ack = 1'b1;
      o_rdata = mem[i_addr[3:0]];
      // true content returned, flagged as write-only
      o_wo = (i_addr == WO_ADDR);
    end else if (i_wr) begin
      cnt = 2'h0;
      o_ack = 1'b1;
      // whole byte stored back at the same address
      mem[i_addr[3:0]] = i_wdata;
      o_wr_cnt++;
      o_last_wdata = i_wdata;
    end else begin
      o_rdata = ~o_rdata;
    end
  end
endmodule

/* bsbu_top_checker.sv */
// Port-level checks on the byte shift and bit operation unit
`timescale 1ns/1ps
module bsbu_top_checker #(
  parameter int unsigned ADDR_W = 16
) (
  // Clock, reset and command
  input wire logic              i_clk_sys,
  input wire logic              i_resetn,
  input wire logic              i_cmd_valid,
  input wire logic [4:0]        i_cmd_op,
  input wire logic              i_cmd_use_mem,
  input wire logic              i_cmd_bit_from_reg,
  // Results
  input wire logic              o_busy,
  input wire logic              o_done,
  input wire logic              o_error,
  input wire logic              o_reg_wr_en,
  input wire logic [7:0]        o_reg_wr_data,
  input wire logic              o_carry_wr_en,
  input wire logic              o_zero_wr_en,
  input wire logic              o_zero,
  // Memory bus
  input wire logic              o_mem_rd,
  input wire logic              o_mem_wr,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [7:0]        o_mem_wdata,
  input wire logic              i_mem_ack
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  logic acc;
  logic inv;
  logic bad;
  // Acceptance and refusal decode, kept apart from the design's helpers
  assign acc = i_cmd_valid && !o_busy && !o_mem_rd && !o_mem_wr;
  assign inv = i_cmd_op inside {5'h0D, 5'h0F, 5'h11, 5'h13, 5'h15};
  assign bad = (inv && i_cmd_bit_from_reg) || i_cmd_op > 5'h15 ||
               (i_cmd_op <= 5'h07 && i_cmd_use_mem);

  sequence reg_walk;
    o_busy ##1 (o_done && !o_busy && !o_error);
  endsequence
  sequence rd_taken;
    o_mem_rd && i_mem_ack;
  endsequence

  chk_reg_timing: assert property (acc && !i_cmd_use_mem && !bad |=>
    reg_walk) else $error("register command timing wrong");
  chk_shift_flags: assert property (acc && !bad && i_cmd_op <= 5'h07 |->
    ##2 (o_reg_wr_en && o_carry_wr_en && o_zero_wr_en &&
    o_zero == (o_reg_wr_data == 8'h00))) else $error("shift flags wrong");
  chk_ro_no_write: assert property (acc && i_cmd_op inside {[5'h0B:5'h13]}
    |=> (!o_mem_wr && !o_reg_wr_en) until o_done)
    else $error("read-only operation wrote");
  chk_done_bound: assert property (acc |-> ##[1:20] o_done)
    else $error("command never finished");
  chk_refuse_inv: assert property (acc && bad |=> o_done && o_error &&
    !o_reg_wr_en && !o_mem_rd) else $error("refusal not shown");
  chk_rmw_order: assert property ($rose(o_mem_wr) |->
    $past(o_mem_rd, 2) && $past(i_mem_ack, 2))
    else $error("write without read");
  chk_rmw_addr: assert property (rd_taken ##1 !o_mem_rd ##1 o_mem_wr |->
    o_mem_addr == $past(o_mem_addr, 2)) else $error("write address moved");
  chk_wr_held: assert property (o_mem_wr && !i_mem_ack |=> o_mem_wr &&
    $stable(o_mem_wdata) && $stable(o_mem_addr)) else $error("write dropped");
  chk_req_drop: assert property ((o_mem_rd || o_mem_wr) && i_mem_ack |=>
    !o_mem_rd && !o_mem_wr) else $error("request held after ack");
  chk_no_overlap: assert property (!(o_mem_rd && o_mem_wr))
    else $error("read and write overlap");
endmodule

bind bsbu_top bsbu_top_checker #(.ADDR_W(ADDR_W)) u_chk (.i_clk_sys,
  .i_resetn, .i_cmd_valid, .i_cmd_op, .i_cmd_use_mem, .i_cmd_bit_from_reg,
  .o_busy, .o_done, .o_error, .o_reg_wr_en, .o_reg_wr_data, .o_carry_wr_en,
  .o_zero_wr_en, .o_zero, .o_mem_rd, .o_mem_wr, .o_mem_addr, .o_mem_wdata,
  .i_mem_ack);

/* byte_shift_and_bit_ops_unit_bench.sv */
// Self-checking bench for the byte shift and bit operation unit
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module byte_shift_and_bit_ops_unit_bench;
  logic        i_clk_sys, i_resetn, i_cmd_valid, i_cmd_use_mem;
  logic        i_cmd_bit_from_reg, i_carry, i_mem_wo, i_mem_ack;
  logic [4:0]  i_cmd_op;
  logic [2:0]  i_cmd_bit_imm;
  logic [7:0]  i_cmd_bit_reg, i_cmd_reg_data, i_mem_rdata, o_reg_wr_data;
  logic [15:0] i_cmd_addr, o_mem_addr;
  logic        o_busy, o_done, o_error, o_reg_wr_en, o_carry_wr_en, o_carry;
  logic        o_zero_wr_en, o_zero, o_mem_rd, o_mem_wr;
  logic [7:0]  o_mem_wdata, wr_cnt, last_wdata, g_r;
  logic [1:0]  lat;
  logic        g_rw, g_cw, g_c, g_zw, g_z;
  int          failures, total_checks, cycles;

  bsbu_top dut (.i_clk_sys, .i_resetn, .i_cmd_valid, .i_cmd_op,
    .i_cmd_use_mem, .i_cmd_bit_from_reg, .i_cmd_bit_imm, .i_cmd_bit_reg,
    .i_cmd_reg_data, .i_cmd_addr, .i_carry, .o_busy, .o_done, .o_error,
    .o_reg_wr_en, .o_reg_wr_data, .o_carry_wr_en, .o_carry, .o_zero_wr_en,
    .o_zero, .o_mem_rd, .o_mem_wr, .o_mem_addr, .o_mem_wdata, .i_mem_rdata,
    .i_mem_wo, .i_mem_ack);
  bsbu_mem_model u_mem (.i_clk_sys, .i_lat(lat), .i_rd(o_mem_rd),
    .i_wr(o_mem_wr), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
    .o_rdata(i_mem_rdata), .o_wo(i_mem_wo), .o_ack(i_mem_ack),
    .o_wr_cnt(wr_cnt), .o_last_wdata(last_wdata));

  // Reference result of one operation on byte d, bit b, carry c
  function automatic void expect_op(input logic [4:0] op,
      input logic [7:0] d, input logic [2:0] b, input logic c,
      output logic [7:0] r, output logic rw, cw, co, zw, zo);
    logic x;
    logic s;
    x = d[b];
    r = d;
    co = c;
    zo = ~x;
    rw = op inside {5'h08, 5'h09, 5'h0A, 5'h14, 5'h15};
    cw = op inside {[5'h0C:5'h13]};
    zw = (op == 5'h0B);
    // one place per op, out-bit into carry
    if (op <= 5'h07) begin
      case (op[2:1])
        2'h0: s = op[0] ? d[7] : 1'b0;
        2'h1: s = 1'b0;
        2'h2: s = op[0] ? d[0] : d[7];
        default: s = c;
      endcase
      r = op[0] ? {s, d[7:1]} : {d[6:0], s};
      co = op[0] ? d[0] : d[7];
      {rw, cw, zw} = 3'h7;
      zo = (r == 8'h00);
    end
    case (op)
      5'h08: r[b] = 1'b1;
      5'h09: r[b] = 1'b0;
      5'h0A: r[b] = ~x;
      5'h0C: co = c & x;
      5'h0D: co = c & ~x;
      5'h0E: co = c | x;
      5'h0F: co = c | ~x;
      5'h10: co = c ^ x;
      5'h11: co = c ^ ~x;
      5'h12: co = x;
      5'h13: co = ~x;
      5'h14: r[b] = c;
      5'h15: r[b] = ~c;
      default: ;
    endcase
  endfunction

  // Issue one command, collect pulses until done, then judge them
  task automatic run(input logic [4:0] op, input logic mem, frg,
      input logic [2:0] b, input logic [7:0] d, input logic c,
      input logic [15:0] a, input logic rf);
    int n;
    logic [7:0] w0, r;
    logic rw, cw, co, zw, zo;
    w0 = wr_cnt;
    @(posedge i_clk_sys);
    #1;
    {i_cmd_valid, i_cmd_op, i_cmd_use_mem, i_cmd_bit_from_reg} =
      {1'b1, op, mem, frg};
    // With the register as source the immediate carries a different bit number, so a mix-up shows; the register always carries b
    i_cmd_bit_imm = frg ? ~b : b;
    i_cmd_bit_reg = {5'h15, b};
    i_cmd_reg_data = mem ? ~d : d;
    {i_cmd_addr, i_carry} = {a, c};
    {g_rw, g_cw, g_zw, n} = '0;
    do begin
      @(posedge i_clk_sys);
      #1;
      i_cmd_valid = 1'b0;
      n++;
      if (o_reg_wr_en === 1'b1) {g_rw, g_r} = {1'b1, o_reg_wr_data};
      if (o_carry_wr_en === 1'b1) {g_cw, g_c} = {1'b1, o_carry};
      if (o_zero_wr_en === 1'b1) {g_zw, g_z} = {1'b1, o_zero};
    end while (o_done !== 1'b1 && n < 40);
    expect_op(op, d, b, c, r, rw, cw, co, zw, zo);
    if (rf) {rw, cw, zw} = 3'h0;
    `CHK(o_done, 1'b1)
    `CHK(o_error, rf)
    `CHK(g_rw, rw & ~mem)
    `CHK(wr_cnt - w0, {7'h00, rw & mem})
    if (rw) `CHK(mem ? last_wdata : g_r, r)
    `CHK(g_cw, cw)
    if (cw) `CHK(g_c, co)
    `CHK(g_zw, zw)
    if (zw) `CHK(g_z, zo)
  endtask

  // All eight shifts and rotates, carry in both states
  task automatic t_shift();
    for (int k = 0; k < 16; k++)
      run(k[4:0] & 5'h07, 1'b0, 1'b0, 3'h0, k[3] ? 8'h81 : 8'h01, k[3],
          16'h0000, 1'b0);
    $display("shift test done");
  endtask

  // Every bit op on a register, bit number from register where allowed
  task automatic t_bits();
    logic [4:0] op;
    for (int k = 0; k < 28; k++) begin
      op = 5'h08 + k[5:1];
      // register source used for non-inverted forms
      run(op, 1'b0, !(op inside {5'h0D, 5'h0F, 5'h11, 5'h13, 5'h15}),
          k[0] ? 3'h5 : 3'h6, 8'hA5, k[0], 16'h0000, 1'b0);
    end
    $display("register bit test done");
  endtask

  // Read-modify-write on memory with slow and prompt answers
  task automatic t_mem();
    lat = 2'h2;
    run(5'h09, 1'b1, 1'b0, 3'h0, 8'hFF, 1'b0, 16'h0005, 1'b0);
    lat = 2'h1;
    run(5'h08, 1'b1, 1'b1, 3'h6, 8'h3F, 1'b1, 16'h0003, 1'b0);
    lat = 2'h0;
    run(5'h0B, 1'b1, 1'b0, 3'h7, 8'h7F, 1'b1, 16'h0003, 1'b0);
    run(5'h15, 1'b1, 1'b0, 3'h7, 8'h7F, 1'b0, 16'h0003, 1'b0);
    run(5'h0E, 1'b1, 1'b1, 3'h7, 8'hFF, 1'b0, 16'h0003, 1'b0);
    $display("memory test done");
  endtask

  // Refused commands leave no trace but done with error
  task automatic t_refuse();
    run(5'h0D, 1'b0, 1'b1, 3'h2, 8'h04, 1'b1, 16'h0000, 1'b1);
    run(5'h00, 1'b1, 1'b0, 3'h0, 8'h3F, 1'b0, 16'h0003, 1'b1);
    run(5'h16, 1'b0, 1'b0, 3'h1, 8'h55, 1'b0, 16'h0000, 1'b1);
    $display("refusal test done");
  endtask

  // Report and end the run
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Free-running clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("Error at %0t: run too long", $time);
      close_out();
    end
  end

  // Main sequence
  initial begin
    {failures, total_checks, cycles} = '0;
    {i_resetn, i_cmd_valid, i_cmd_use_mem, i_cmd_bit_from_reg} = 4'h0;
    {i_carry, i_cmd_op, i_cmd_bit_imm, i_cmd_bit_reg} = '0;
    {i_cmd_reg_data, i_cmd_addr, lat} = '0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    i_resetn = 1'b1;
    t_shift();
    t_bits();
    t_mem();
    t_refuse();
    close_out();
  end
endmodule
